// ===== verilog/irq_flags_pkg.sv
// constants, register map and state type of the interrupt flag and mask block
// Notes on behaviour
// - main mask bits 7..2: osc, water level, rx start, rx end, tx end, collision
// - timer/field mask bits 7..0: cmd end, nrt, gpt, field on/off, ca, guard, bitrate
// - error/wake mask bits 7..0: crc, parity, soft, hard frame, wake timer, amp, phase, cap
// - all masks reset to zero at power-up and on set-default
// - summary bit 7 sets when enabled oscillator becomes stable
// - summary bit 6 sets while receiving when fifo is nearly full
// - summary bit 6 sets while transmitting when fifo is nearly empty
// - summary bits 5..2: rx start, rx end, tx end, bit collision
// - summary bits 1 and 0 show pending timer/field and error/wake flags
// - reading summary clears bits 7..2; bits 1..0 clear via detail reads
// - source registers clear to zero at power-up and on set-default
// - timer/field bits 7..5: command end, no-response timer, general timer
// - bit 4 on field rising above level, bit 3 on falling below
// - bit 2 when external field sensed during collision avoidance
// - bit 1 after guard time once own field switched on
// - bit 0 when target mode recognises initiator bit rate
// - reading timer/field register clears it
// - error/wake register: bits 7..4 errors, bits 3..0 wake-up events
package irq_flags_pkg;

  // ------------------------------------------------------------
  // register indices, byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [5:0] MAIN_MASK_IDX = 6'h14;
  localparam logic [5:0] TF_MASK_IDX = 6'h15;
  localparam logic [5:0] EW_MASK_IDX = 6'h16;
  localparam logic [5:0] SUMMARY_IDX = 6'h17;
  localparam logic [5:0] TF_FLAGS_IDX = 6'h18;
  localparam logic [5:0] EW_FLAGS_IDX = 6'h19;
  localparam logic [5:0] CONTROL_IDX = 6'h1f;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int CTRL_DEFAULT_BIT = 0;
  localparam int SUM_OSC = 7;
  localparam int SUM_WL = 6;
  localparam int SUM_RXS = 5;
  localparam int SUM_RXE = 4;
  localparam int SUM_TXE = 3;
  localparam int SUM_COL = 2;
  localparam int SUM_TF = 1;
  localparam int SUM_EW = 0;
  localparam int TF_DCT = 7;
  localparam int TF_NRE = 6;
  localparam int TF_GPE = 5;
  localparam int TF_EON = 4;
  localparam int TF_EOF = 3;
  localparam int TF_CAC = 2;
  localparam int TF_CAT = 1;
  localparam int TF_NFCT = 0;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ------------------------------------------------------------
  // complete state of the block
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] main_mask;
    logic [7:0] tf_mask;
    logic [7:0] ew_mask;
    logic [7:2] main_flags;
    logic [7:0] tf_flags;
    logic [7:0] ew_flags;
    logic osc_seen;
    logic field_q;
    logic [7:0] rdata;
    logic err;
    logic irq;
  } state_t;

endpackage

// ===== verilog/reader_interrupt_flags_and_masks.sv
// interrupt source flags, masks and apb register access of the reader front end
//
// Decided for this implementation: the APB register port.
module reader_interrupt_flags_and_masks (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // main event sources
  input wire logic osc_enable,
  input wire logic osc_stable,
  input wire logic receiving,
  input wire logic transmitting,
  input wire logic fifo_nearly_full,
  input wire logic fifo_nearly_empty,
  input wire logic rx_start_evt,
  input wire logic rx_end_evt,
  input wire logic tx_end_evt,
  input wire logic bit_collision_evt,
  // timer and field event sources
  input wire logic cmd_done_evt,
  input wire logic nrt_expired_evt,
  input wire logic gpt_expired_evt,
  input wire logic field_above,
  input wire logic ca_collision_evt,
  input wire logic ca_guard_done_evt,
  input wire logic target_mode,
  input wire logic bitrate_found_evt,
  // error and wake-up event sources
  input wire logic [7:0] err_wake_evt,
  // interrupt
  output logic irq
);

  irq_flags_pkg::state_t s_r;
  irq_flags_pkg::state_t s_nxt;
  logic [5:0] idx;
  logic aligned;
  logic rd_setup;
  logic rd_done;
  logic wr_done;
  logic set_default;
  logic [7:0] m_set;
  logic [7:0] t_set;
  logic [7:0] summary;
  logic [7:2] m_clr;
  logic [7:0] t_clr;
  logic [7:0] e_clr;

  // ------------------------------------------------------------
  // bus phase decode
  // ------------------------------------------------------------
  assign idx = paddr[7:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign rd_setup = psel & ~penable & ~pwrite;
  assign rd_done = psel & penable & ~pwrite;
  assign wr_done = psel & penable & pwrite;
  assign set_default = wr_done & aligned & (idx == irq_flags_pkg::CONTROL_IDX)
                       & pwdata[irq_flags_pkg::CTRL_DEFAULT_BIT];

  // ------------------------------------------------------------
  // event decode into flag set vectors
  // ------------------------------------------------------------
  // main source events
  assign m_set[irq_flags_pkg::SUM_OSC] = osc_enable & osc_stable & ~s_r.osc_seen;
  assign m_set[irq_flags_pkg::SUM_WL] = (receiving & fifo_nearly_full)
                                        | (transmitting & fifo_nearly_empty);
  assign m_set[irq_flags_pkg::SUM_RXS] = rx_start_evt;
  assign m_set[irq_flags_pkg::SUM_RXE] = rx_end_evt;
  assign m_set[irq_flags_pkg::SUM_TXE] = tx_end_evt;
  assign m_set[irq_flags_pkg::SUM_COL] = bit_collision_evt;
  assign m_set[1:0] = 2'b00; // summary low bits are derived, never stored

  // timer and field source events
  assign t_set[irq_flags_pkg::TF_DCT] = cmd_done_evt;
  assign t_set[irq_flags_pkg::TF_NRE] = nrt_expired_evt;
  assign t_set[irq_flags_pkg::TF_GPE] = gpt_expired_evt;
  assign t_set[irq_flags_pkg::TF_EON] = field_above & ~s_r.field_q;
  assign t_set[irq_flags_pkg::TF_EOF] = ~field_above & s_r.field_q;
  assign t_set[irq_flags_pkg::TF_CAC] = ca_collision_evt;
  assign t_set[irq_flags_pkg::TF_CAT] = ca_guard_done_evt;
  assign t_set[irq_flags_pkg::TF_NFCT] = target_mode & bitrate_found_evt;

  // summary view, bits 1 and 0 follow the detail registers
  assign summary = {s_r.main_flags, |s_r.tf_flags, |s_r.ew_flags};

  // ------------------------------------------------------------
  // clear vectors: a read clears only the bits it handed out, set-default clears all bits
  // ------------------------------------------------------------
  always_comb begin
    m_clr = '0;
    t_clr = '0;
    e_clr = '0;
    if (set_default) begin
      m_clr = '1;
      t_clr = '1;
      e_clr = '1;
    end else if (rd_done && aligned) begin
      case (idx)
        irq_flags_pkg::SUMMARY_IDX: m_clr = s_r.rdata[7:2];
        irq_flags_pkg::TF_FLAGS_IDX: t_clr = s_r.rdata[7:0];
        irq_flags_pkg::EW_FLAGS_IDX: e_clr = s_r.rdata[7:0];
        default: m_clr = '0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.osc_seen = osc_enable & osc_stable;
    s_nxt.field_q = field_above;
    // set wins over a clear in the same cycle
    s_nxt.main_flags = (s_r.main_flags & ~m_clr) | m_set[7:2];
    s_nxt.tf_flags = (s_r.tf_flags & ~t_clr) | t_set;
    s_nxt.ew_flags = (s_r.ew_flags & ~e_clr) | err_wake_evt;
    // mask writes
    if (wr_done && aligned) begin
      case (idx)
        irq_flags_pkg::MAIN_MASK_IDX: s_nxt.main_mask = {pwdata[7:2], 2'b00};
        irq_flags_pkg::TF_MASK_IDX: s_nxt.tf_mask = pwdata[7:0];
        irq_flags_pkg::EW_MASK_IDX: s_nxt.ew_mask = pwdata[7:0];
        default: s_nxt.main_mask = s_r.main_mask;
      endcase
    end
    if (set_default) begin
      s_nxt.main_mask = irq_flags_pkg::REG_RESET;
      s_nxt.tf_mask = irq_flags_pkg::REG_RESET;
      s_nxt.ew_mask = irq_flags_pkg::REG_RESET;
    end
    // setup phase: snapshot read data and error answer
    if (psel && !penable) begin
      s_nxt.rdata = '0;
      s_nxt.err = ~aligned;
      case (idx)
        irq_flags_pkg::MAIN_MASK_IDX: s_nxt.rdata = s_r.main_mask;
        irq_flags_pkg::TF_MASK_IDX: s_nxt.rdata = s_r.tf_mask;
        irq_flags_pkg::EW_MASK_IDX: s_nxt.rdata = s_r.ew_mask;
        irq_flags_pkg::SUMMARY_IDX: s_nxt.rdata = summary;
        irq_flags_pkg::TF_FLAGS_IDX: s_nxt.rdata = s_r.tf_flags;
        irq_flags_pkg::EW_FLAGS_IDX: s_nxt.rdata = s_r.ew_flags;
        irq_flags_pkg::CONTROL_IDX: s_nxt.rdata = '0;
        default: s_nxt.err = 1'b1;
      endcase
      // flag registers are read only
      if (pwrite && (idx == irq_flags_pkg::SUMMARY_IDX || idx == irq_flags_pkg::TF_FLAGS_IDX
          || idx == irq_flags_pkg::EW_FLAGS_IDX)) begin
        s_nxt.err = 1'b1;
      end
      if (s_nxt.err) begin
        s_nxt.rdata = '0;
      end
    end
    // unmasked pending flags drive the interrupt
    s_nxt.irq = (|(s_r.main_flags & ~s_r.main_mask[7:2]))
                | (|(s_r.tf_flags & ~s_r.tf_mask))
                | (|(s_r.ew_flags & ~s_r.ew_mask));
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign pready = psel & penable; // one wait-free access phase
  assign prdata = {24'h00_0000, s_r.rdata};
  assign pslverr = s_r.err;
  assign irq = s_r.irq;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_sum_read;
    rd_setup && aligned && idx == irq_flags_pkg::SUMMARY_IDX ##1 rd_done;
  endsequence

  property p_main_mask_wr;
    wr_done && aligned && idx == irq_flags_pkg::MAIN_MASK_IDX && !set_default
      |=> s_r.main_mask == {$past(pwdata[7:2]), 2'b00};
  endproperty
  a_main_mask_wr: assert property (p_main_mask_wr) else $error("main mask write lost");

  property p_tf_mask_wr;
    wr_done && aligned && idx == irq_flags_pkg::TF_MASK_IDX |=> s_r.tf_mask == $past(pwdata[7:0]);
  endproperty
  a_tf_mask_wr: assert property (p_tf_mask_wr) else $error("timer mask write lost");

  property p_ew_mask_wr;
    wr_done && aligned && idx == irq_flags_pkg::EW_MASK_IDX |=> s_r.ew_mask == $past(pwdata[7:0]);
  endproperty
  a_ew_mask_wr: assert property (p_ew_mask_wr) else $error("error mask write lost");

  property p_default;
    set_default |=> s_r.main_mask == 8'h00 && s_r.tf_mask == 8'h00 && s_r.ew_mask == 8'h00
      && (s_r.tf_flags & ~$past(t_set)) == 8'h00;
  endproperty
  a_default: assert property (p_default) else $error("set default left state");

  property p_osc;
    osc_enable && osc_stable && !$past(osc_stable) |=> s_r.main_flags[7];
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator flag missing");

  property p_wl;
    (receiving && fifo_nearly_full) || (transmitting && fifo_nearly_empty)
      |=> s_r.main_flags[6] ##1 irq || $past(s_r.main_mask[6]);
  endproperty
  a_wl: assert property (p_wl) else $error("water level flag or irq missing");

  property p_sum_clear;
    s_sum_read ##0 m_set == 8'h00 |=> (s_r.main_flags & $past(s_r.rdata[7:2], 1)) == 6'h00;
  endproperty
  a_sum_clear: assert property (p_sum_clear) else $error("summary not cleared");

  property p_sum_keeps_tf;
    s_sum_read ##0 s_r.tf_flags != 8'h00 |=> s_r.tf_flags != 8'h00;
  endproperty
  a_sum_keeps_tf: assert property (p_sum_keeps_tf) else $error("detail lost on summary read");

  property p_field;
    field_above && !s_r.field_q |=> s_r.tf_flags[4] ##0 !s_r.tf_flags[3] || $past(s_r.tf_flags[3]);
  endproperty
  a_field: assert property (p_field) else $error("field on flag missing");

  property p_tf_clear;
    rd_done && aligned && idx == irq_flags_pkg::TF_FLAGS_IDX && t_set == 8'h00 && !set_default
      |=> (s_r.tf_flags & $past(s_r.rdata)) == 8'h00;
  endproperty
  a_tf_clear: assert property (p_tf_clear) else $error("timer flags not cleared");

  property p_irq_blocked;
    s_r.main_mask[7:2] == 6'h3f && s_r.tf_mask == 8'hff && s_r.ew_mask == 8'hff
      [*2] |-> !irq;
  endproperty
  a_irq_blocked: assert property (p_irq_blocked) else $error("masked source raised irq");

  property p_ew_set;
    err_wake_evt != 8'h00 |=> (s_r.ew_flags & $past(err_wake_evt)) == $past(err_wake_evt)
      ##1 summary[0] || $past(rd_done) || $past(set_default);
  endproperty
  a_ew_set: assert property (p_ew_set) else $error("error flag missing");

  // error and wake-up register read by the host
  sequence s_ew_read;
    rd_setup && aligned && idx == irq_flags_pkg::EW_FLAGS_IDX ##1 rd_done;
  endsequence

  // main source flags
  property p_wl_tx;
    transmitting && fifo_nearly_empty |=> s_r.main_flags[irq_flags_pkg::SUM_WL];
  endproperty
  a_wl_tx: assert property (p_wl_tx) else $error("transmit level flag missing");

  property p_rxs;
    rx_start_evt |=> s_r.main_flags[irq_flags_pkg::SUM_RXS];
  endproperty
  a_rxs: assert property (p_rxs) else $error("receive start flag missing");

  property p_col;
    bit_collision_evt |=> s_r.main_flags[irq_flags_pkg::SUM_COL];
  endproperty
  a_col: assert property (p_col) else $error("collision flag missing");

  property p_osc_hold;
    !s_r.main_flags[irq_flags_pkg::SUM_OSC] && !(osc_enable && osc_stable)
      |=> !s_r.main_flags[irq_flags_pkg::SUM_OSC];
  endproperty
  a_osc_hold: assert property (p_osc_hold) else $error("oscillator flag unprompted");

  // register reads, read clears and set-default clears
  property p_mask_low;
    rd_setup && aligned && idx == irq_flags_pkg::MAIN_MASK_IDX |=> s_r.rdata[1:0] == 2'b00;
  endproperty
  a_mask_low: assert property (p_mask_low) else $error("mask low bits read as one");

  property p_tf_mask_rd;
    rd_setup && aligned && idx == irq_flags_pkg::TF_MASK_IDX
      |=> s_r.rdata == $past(s_r.tf_mask);
  endproperty
  a_tf_mask_rd: assert property (p_tf_mask_rd) else $error("timer mask read wrong");

  property p_ew_mask_rd;
    rd_setup && aligned && idx == irq_flags_pkg::EW_MASK_IDX
      |=> s_r.rdata == $past(s_r.ew_mask);
  endproperty
  a_ew_mask_rd: assert property (p_ew_mask_rd) else $error("error mask read wrong");

  property p_sum_tf_bit;
    rd_setup && aligned && idx == irq_flags_pkg::SUMMARY_IDX && s_r.tf_flags != 8'h00
      |=> s_r.rdata[irq_flags_pkg::SUM_TF];
  endproperty
  a_sum_tf_bit: assert property (p_sum_tf_bit) else $error("summary bit 1 missing");

  property p_sum_keeps_ew;
    s_sum_read ##0 s_r.ew_flags != 8'h00 |=> s_r.ew_flags != 8'h00;
  endproperty
  a_sum_keeps_ew: assert property (p_sum_keeps_ew) else $error("error detail lost");

  property p_ew_clear;
    s_ew_read ##0 err_wake_evt == 8'h00 |=> (s_r.ew_flags & $past(s_r.rdata)) == 8'h00;
  endproperty
  a_ew_clear: assert property (p_ew_clear) else $error("error flags not cleared");

  property p_dflt_flags;
    set_default |=> (s_r.main_flags & ~$past(m_set[7:2])) == 6'h00
      && (s_r.ew_flags & ~$past(err_wake_evt)) == 8'h00;
  endproperty
  a_dflt_flags: assert property (p_dflt_flags) else $error("set default left flags");

  // timer and field flags
  property p_tf_pulses;
    cmd_done_evt || nrt_expired_evt || gpt_expired_evt
      |=> (s_r.tf_flags[7:5] & $past({cmd_done_evt, nrt_expired_evt, gpt_expired_evt}))
        == $past({cmd_done_evt, nrt_expired_evt, gpt_expired_evt});
  endproperty
  a_tf_pulses: assert property (p_tf_pulses) else $error("timer flag missing");

  property p_field_off;
    !field_above && s_r.field_q |=> s_r.tf_flags[irq_flags_pkg::TF_EOF];
  endproperty
  a_field_off: assert property (p_field_off) else $error("field off flag missing");

  property p_field_quiet;
    field_above == s_r.field_q && !s_r.tf_flags[irq_flags_pkg::TF_EON]
      |=> !s_r.tf_flags[irq_flags_pkg::TF_EON];
  endproperty
  a_field_quiet: assert property (p_field_quiet) else $error("field flag unprompted");

  property p_ca_col;
    ca_collision_evt |=> s_r.tf_flags[irq_flags_pkg::TF_CAC];
  endproperty
  a_ca_col: assert property (p_ca_col) else $error("avoidance collision flag missing");

  property p_guard;
    ca_guard_done_evt |=> s_r.tf_flags[irq_flags_pkg::TF_CAT];
  endproperty
  a_guard: assert property (p_guard) else $error("guard time flag missing");

  property p_bitrate;
    target_mode && bitrate_found_evt |=> s_r.tf_flags[irq_flags_pkg::TF_NFCT];
  endproperty
  a_bitrate: assert property (p_bitrate) else $error("bit rate flag missing");

  property p_rate_idle;
    !target_mode && !s_r.tf_flags[irq_flags_pkg::TF_NFCT]
      |=> !s_r.tf_flags[irq_flags_pkg::TF_NFCT];
  endproperty
  a_rate_idle: assert property (p_rate_idle) else $error("bit rate flag unprompted");

  // error flags and interrupt output
  property p_ew_quiet;
    err_wake_evt == 8'h00 && s_r.ew_flags == 8'h00 |=> s_r.ew_flags == 8'h00;
  endproperty
  a_ew_quiet: assert property (p_ew_quiet) else $error("error flag unprompted");

  property p_irq_on;
    (s_r.main_flags & ~s_r.main_mask[7:2]) != 6'h00 || (s_r.tf_flags & ~s_r.tf_mask) != 8'h00
      || (s_r.ew_flags & ~s_r.ew_mask) != 8'h00 |=> irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("unmasked flag without irq");

  property p_irq_idle;
    s_r.main_flags == 6'h00 && s_r.tf_flags == 8'h00 && s_r.ew_flags == 8'h00 |=> !irq;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("irq without flag");

endmodule // reader_interrupt_flags_and_masks

// ===== verif/event_source_model.sv
// event source model: turns bench requests into event pulses one cycle later
module event_source_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pulse requests from the bench
  input wire logic [17:0] req,
  // event pulses toward the block
  output logic [3:0] main_pulse,
  output logic [5:0] tf_pulse,
  output logic [7:0] ew_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  // pulses leave a flop, one cycle after the request, as a real source would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {ew_pulse, tf_pulse, main_pulse} <= 18'h0_0000;
    end else begin
      {ew_pulse, tf_pulse, main_pulse} <= req;
    end
  end
endmodule // event_source_model

// ===== verif/reader_interrupt_flags_and_masks_tb.sv
// self-checking bench of the interrupt flag and mask block
module reader_interrupt_flags_and_masks_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0] paddr, msk, e;
  logic [31:0] pwdata, prdata, rd, seed;
  logic osc_enable, osc_stable, receiving, transmitting, nfull, nempty, field_above, target_mode;
  logic [17:0] req, r;
  logic [3:0] mp;
  logic [5:0] tp;
  logic [7:0] ewp;
  int fail_count, n_tests;

  reader_interrupt_flags_and_masks u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_enable(osc_enable), .osc_stable(osc_stable),
    .receiving(receiving), .transmitting(transmitting), .fifo_nearly_full(nfull),
    .fifo_nearly_empty(nempty), .rx_start_evt(mp[3]), .rx_end_evt(mp[2]),
    .tx_end_evt(mp[1]), .bit_collision_evt(mp[0]), .cmd_done_evt(tp[5]),
    .nrt_expired_evt(tp[4]), .gpt_expired_evt(tp[3]), .field_above(field_above),
    .ca_collision_evt(tp[2]), .ca_guard_done_evt(tp[1]), .target_mode(target_mode),
    .bitrate_found_evt(tp[0]), .err_wake_evt(ewp), .irq(irq));

  event_source_model u_src (.pclk(pclk), .presetn(presetn), .req(req), .main_pulse(mp),
    .tf_pulse(tp), .ew_pulse(ewp));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one apb transfer: setup, then access held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      fail_count++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h00_0000, exp});
    chk({31'h0, err}, 32'h0000_0000);
  endtask

  // request pulses and levels; lv[2:0] last one cycle, lv[4:3] stay
  task automatic fire(input logic [17:0] q, input logic [4:0] lv);
    @(posedge pclk);
    req <= q;
    osc_enable <= lv[0];
    osc_stable <= lv[0];
    receiving <= lv[1];
    nfull <= lv[1];
    transmitting <= lv[2];
    nempty <= lv[2];
    field_above <= lv[3];
    target_mode <= lv[4];
    @(posedge pclk);
    req <= 18'h0_0000;
    {osc_enable, osc_stable, receiving, nfull, transmitting, nempty} <= 6'h00;
    repeat (3) @(posedge pclk);
  endtask

  task automatic all_zero;
    for (int i = 0; i < 6; i++) rdchk(8'h50 + 8'(i * 4), 8'h00);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata, req} = '0;
    {osc_enable, osc_stable, receiving, transmitting, nfull, nempty} = 6'h00;
    field_above = 1'b0;
    target_mode = 1'b0;
    presetn = 1'b0;
    seed = 32'h0000_ac79;
    fail_count = 0;
    n_tests = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    all_zero();
    // main sources; code 1 is the transmit water level case
    for (int b = 7; b >= 1; b--) begin
      seed = lfsr(seed);
      msk = seed[7:0];
      r = (b >= 2 && b <= 5) ? 18'(1 << (b - 2)) : 18'h0_0000;
      apb(1'b1, 8'h50, msk);
      rdchk(8'h50, msk & 8'hfc);
      fire(r, {2'b00, b == 1, b == 6, b == 7});
      chk({31'h0, irq}, {31'h0, ~msk[b == 1 ? 6 : b]});
      rdchk(8'h5c, 8'(1 << (b == 1 ? 6 : b)));
      rdchk(8'h5c, 8'h00);
      chk({31'h0, irq}, 32'h0000_0000);
    end
    // timer and field sources
    for (int b = 7; b >= 0; b--) begin
      seed = lfsr(seed);
      msk = seed[7:0];
      r = 18'h0_0000;
      if (b >= 5) r[b + 2] = 1'b1;
      else if (b <= 2) r[b + 4] = 1'b1;
      apb(1'b1, 8'h54, msk);
      rdchk(8'h54, msk);
      fire(r, {b == 0, b == 4, 3'b000});
      chk({31'h0, irq}, {31'h0, ~msk[b]});
      rdchk(8'h5c, 8'h02);
      rdchk(8'h5c, 8'h02);
      rdchk(8'h60, 8'(1 << b));
      rdchk(8'h5c, 8'h00);
    end
    // error and wake-up sources, random patterns
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      msk = seed[15:8];
      e = seed[7:0] | 8'h01;
      apb(1'b1, 8'h58, msk);
      rdchk(8'h58, msk);
      fire({e, 10'h000}, 5'h00);
      chk({31'h0, irq}, {31'h0, |(e & ~msk)});
      rdchk(8'h5c, 8'h01);
      rdchk(8'h64, e);
      rdchk(8'h5c, 8'h00);
    end
    // refused accesses: unmapped, unaligned, write to a flag register
    apb(1'b0, 8'h00, 8'h00);
    chk({31'h0, err}, 32'h0000_0001);
    apb(1'b1, 8'h5c, 8'hff);
    chk({31'h0, err}, 32'h0000_0001);
    apb(1'b0, 8'h51, 8'h00);
    chk({31'h0, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    rdchk(8'h7c, 8'h00);
    // everything masked, then set-default clears masks and flags
    for (int i = 0; i < 3; i++) apb(1'b1, 8'h50 + 8'(i * 4), 8'hff);
    fire(18'h3_ffff, 5'h00);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, 8'h7c, 8'h01);
    all_zero();
    // timer/field mask and flags set again, then a reset in mid-run must clear them
    apb(1'b1, 8'h54, 8'h5a);
    fire(18'h3_ffff, 5'h00);
    chk({31'h0, irq}, 32'h0000_0001);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    all_zero();
    end_sim();
  end
endmodule // reader_interrupt_flags_and_masks_tb
